// ---- src/rst_seq_pkg.sv ----
// Shared constants and types for the reset entry and exit sequencer
package rst_seq_pkg;

  localparam logic [19:0] RESET_VECTOR = 20'hffff0;
  localparam int CLK_PERIOD_NS = 50;
  // External reset input must be held at least this long (board side)
  localparam int MIN_EXT_RESET_NS = 1000000;
  localparam int MIN_EXT_RESET_CYC =
    (MIN_EXT_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Clock must be stable this many periods while reset is held
  localparam int MIN_STABLE_CLKS = 4;
  localparam int SYNC_STAGES = 2;
  // Reset output stays high this many clocks after release
  localparam int RST_OUT_HOLD_CYC = 2;
  // Exit points after release, given in half clock periods
  localparam int BUS_START_HALF = 9;
  localparam int FETCH_START_HALF = 13;
  localparam int BUS_START_CYC = (BUS_START_HALF + 1) / 2;
  localparam int FETCH_START_CYC = (FETCH_START_HALF + 1) / 2;
  localparam int WDT_EXIT_EXP = 16;
  localparam int WDT_EXIT_DEFAULT = 2 ** WDT_EXIT_EXP;
  localparam int SEQ_CNT_W = WDT_EXIT_EXP + 1;
  localparam logic STRAP_RESET_VAL = 1'b1;

  typedef enum logic [1:0] {
    ST_EXT,
    ST_WDT,
    ST_EXIT,
    ST_RUN
  } seq_state_t;

  // Per-UART clock source: 1 selects the external UART clock pin
  typedef struct packed {
    logic hs_uart;
    logic std_uart;
  } uart_clk_sel_t;

  typedef struct packed {
    logic tx_plus;
    logic tx_minus;
    logic output_enable;
  } xcvr_out_t;

endpackage : rst_seq_pkg

// ---- src/reset_level_sync.sv ----
// Reset synchroniser: asserts at once, releases after STAGES clocks
`timescale 1ns/100ps
module reset_level_sync #(
  parameter int STAGES = 2
) (
  input wire logic clk,
  input wire logic arst_n,
  output logic hold
);

  logic [STAGES-1:0] stage_q;
  logic [STAGES-1:0] stage_d;

  // Only the last stage is read outside the chain
  always_comb begin
    stage_d = {stage_q[STAGES-2:0], 1'b0};
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      stage_q <= '1;
    end else begin
      stage_q <= stage_d;
    end
  end

  assign hold = stage_q[STAGES-1];

endmodule : reset_level_sync

// ---- src/reset_entry_exit_sequencer.sv ----
// Reset entry and exit sequencer with UART clock select and strap capture
//
// How it works
// - External reset stops at once and clears state on the next clock
// - Execution starts at fixed vector FFFF0h
// - Asynchronous reset input synchronised before use
// - External reset overrides watchdog reset in progress
// - Override leaves watchdog cause flag cleared
// - Watchdog-only reset exits 2^16 clocks later
// - First bus cycle about 4.5 clocks after release
// - Instruction fetch about 6.5 clocks after release
// - Reset output active for any reset cause
// - Reset output high two clocks after release
// - Each UART picks its clock source independently
// - Strap low at external reset exit enables transceiver pins
`timescale 1ns/100ps
module reset_entry_exit_sequencer
  import rst_seq_pkg::*;
#(
  parameter int WDT_EXIT_CYC = WDT_EXIT_DEFAULT
) (
  input wire logic MCLK,
  input wire logic ARST_N,
  input wire logic EXT_RESET_IN_N,
  input wire logic WDT_TIMEOUT,
  input wire logic FLAG_CLEAR,
  output logic SYSTEM_RESET_DRIVE,
  output logic CPU_RESET,
  output logic BUS_START,
  output logic FETCH_START,
  output logic [19:0] FETCH_ADDR,
  output logic WATCHDOG_RESET_CAUSE_FLAG,
  input wire uart_clk_sel_t UART_CLK_SEL,
  input wire logic UART_EXT_CLOCK_IN,
  output uart_clk_sel_t UART_CLK_TICK,
  input wire logic EXT_TRANSCEIVER_STRAP,
  input wire xcvr_out_t USB_TX,
  output logic USB_RX,
  output xcvr_out_t XCVR_PINS_O,
  output logic XCVR_PINS_OE,
  input wire logic XCVR_RECEIVE_DATA
);

  localparam logic [SEQ_CNT_W-1:0] WDT_LAST =
    SEQ_CNT_W'(WDT_EXIT_CYC - 1);
  localparam logic [SEQ_CNT_W-1:0] HOLD_LAST = SEQ_CNT_W'(RST_OUT_HOLD_CYC);
  localparam logic [SEQ_CNT_W-1:0] BUS_LAST = SEQ_CNT_W'(BUS_START_CYC - 1);
  localparam logic [SEQ_CNT_W-1:0] FETCH_LAST =
    SEQ_CNT_W'(FETCH_START_CYC - 1);

  logic ext_arst_n;
  logic ext_hold;
  seq_state_t state_q, state_d;
  logic [SEQ_CNT_W-1:0] cnt_q, cnt_d;
  logic flag_q, flag_d;
  logic sysrst_q, sysrst_d;
  logic bus_q, bus_d;
  logic fetch_q, fetch_d;
  logic [19:0] addr_q, addr_d;
  logic strap_q, strap_d;
  logic ext_clk_q, ext_clk_d;
  uart_clk_sel_t tick_q, tick_d;
  xcvr_out_t pins_q, pins_d;
  logic rx_q, rx_d;
  logic ext_clk_rise;

  // The pin sets the sync chain to all ones without waiting for a clock edge
  assign ext_arst_n = ARST_N & EXT_RESET_IN_N;

  reset_level_sync #(
    .STAGES(SYNC_STAGES)
  ) u_ext_sync (
    .clk(MCLK),
    .arst_n(ext_arst_n),
    .hold(ext_hold)
  );

  // Sequencer
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    flag_d = flag_q;
    sysrst_d = sysrst_q;
    bus_d = 1'b0;
    fetch_d = 1'b0;
    addr_d = 20'h00000;
    strap_d = strap_q;
    if (FLAG_CLEAR) begin
      flag_d = 1'b0;
    end
    case (state_q)
      ST_EXT: begin
        sysrst_d = 1'b1;
        if (!ext_hold) begin
          // Release edge: the strap is captured exactly here
          state_d = ST_EXIT;
          cnt_d = SEQ_CNT_W'(1);
          strap_d = EXT_TRANSCEIVER_STRAP;
        end
      end
      ST_WDT: begin
        sysrst_d = 1'b1;
        if (cnt_q == WDT_LAST) begin
          flag_d = 1'b1;
          state_d = ST_EXIT;
          cnt_d = SEQ_CNT_W'(1);
        end else begin
          cnt_d = cnt_q + SEQ_CNT_W'(1);
        end
      end
      ST_EXIT: begin
        cnt_d = cnt_q + SEQ_CNT_W'(1);
        if (cnt_q == HOLD_LAST) begin
          sysrst_d = 1'b0;
        end
        if (cnt_q == BUS_LAST) begin
          bus_d = 1'b1;
        end
        if (cnt_q == FETCH_LAST) begin
          fetch_d = 1'b1;
          addr_d = RESET_VECTOR;
          state_d = ST_RUN;
        end
      end
      ST_RUN: begin
        if (WDT_TIMEOUT) begin
          state_d = ST_WDT;
          cnt_d = '0;
          sysrst_d = 1'b1;
        end
      end
      default: begin
        state_d = ST_EXT;
        sysrst_d = 1'b1;
      end
    endcase
    // External reset beats everything, including a pending flag set
    if (ext_hold) begin
      state_d = ST_EXT;
      cnt_d = '0;
      sysrst_d = 1'b1;
      bus_d = 1'b0;
      fetch_d = 1'b0;
      addr_d = 20'h00000;
      flag_d = 1'b0;
    end
  end

  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      state_q <= ST_EXT;
      cnt_q <= '0;
      flag_q <= 1'b0;
      sysrst_q <= 1'b1;
      bus_q <= 1'b0;
      fetch_q <= 1'b0;
      addr_q <= 20'h00000;
      strap_q <= STRAP_RESET_VAL;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      flag_q <= flag_d;
      sysrst_q <= sysrst_d;
      bus_q <= bus_d;
      fetch_q <= fetch_d;
      addr_q <= addr_d;
      strap_q <= strap_d;
    end
  end

  // UART clock ticks and transceiver pins
  assign ext_clk_rise = UART_EXT_CLOCK_IN & ~ext_clk_q;

  always_comb begin
    ext_clk_d = UART_EXT_CLOCK_IN;
    tick_d.std_uart = UART_CLK_SEL.std_uart ? ext_clk_rise : 1'b1;
    tick_d.hs_uart = UART_CLK_SEL.hs_uart ? ext_clk_rise : 1'b1;
    pins_d = strap_q ? '0 : USB_TX;
    rx_d = ~strap_q & XCVR_RECEIVE_DATA;
  end

  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ext_clk_q <= 1'b0;
      tick_q <= '0;
      pins_q <= '0;
      rx_q <= 1'b0;
    end else begin
      ext_clk_q <= ext_clk_d;
      tick_q <= tick_d;
      pins_q <= pins_d;
      rx_q <= rx_d;
    end
  end

  // Reset output rises with the pin at once, not a clock later
  assign SYSTEM_RESET_DRIVE = ext_hold | sysrst_q;
  assign CPU_RESET = ext_hold | (state_q != ST_RUN);
  assign BUS_START = bus_q;
  assign FETCH_START = fetch_q;
  assign FETCH_ADDR = addr_q;
  assign WATCHDOG_RESET_CAUSE_FLAG = flag_q;
  assign UART_CLK_TICK = tick_q;
  assign XCVR_PINS_O = pins_q;
  assign XCVR_PINS_OE = ~strap_q;
  assign USB_RX = rx_q;

  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (!ARST_N);

  sequence s_release;
    state_q == ST_EXT && !ext_hold;
  endsequence

  a_ext_reset_out: assert property (ext_hold |-> SYSTEM_RESET_DRIVE
    && CPU_RESET) else $error("reset output low in ext reset");
  a_system_reset_drive_two_clk: assert property (s_release |=> SYSTEM_RESET_DRIVE [*2]
    ##1 (!SYSTEM_RESET_DRIVE || ext_hold))
    else $error("reset output hold wrong");
  a_bus_start_time: assert property (s_release |-> ##5 (BUS_START
    || ext_hold)) else $error("bus start late or early");
  a_fetch_time: assert property (s_release ##5 !ext_hold ##2 !ext_hold
    |-> FETCH_START) else $error("fetch start wrong");
  a_fetch_vector: assert property (FETCH_START |-> FETCH_ADDR
    == RESET_VECTOR && !CPU_RESET) else $error("bad fetch vector");
  a_wdt_override: assert property (state_q == ST_WDT && ext_hold |=>
    state_q == ST_EXT && !WATCHDOG_RESET_CAUSE_FLAG)
    else $error("watchdog not overridden");
  a_wdt_exit_flag: assert property (state_q == ST_WDT && cnt_q == WDT_LAST
    && !ext_hold |=> WATCHDOG_RESET_CAUSE_FLAG && state_q == ST_EXIT)
    else $error("watchdog exit wrong");
  a_wdt_reset_out: assert property (state_q == ST_WDT |->
    SYSTEM_RESET_DRIVE) else $error("reset out low in watchdog");
  a_strap_sample: assert property (s_release |=> XCVR_PINS_OE
    == !$past(EXT_TRANSCEIVER_STRAP)) else $error("strap not taken");
  a_uart_proc_clk: assert property (!UART_CLK_SEL.std_uart
    |=> UART_CLK_TICK.std_uart) else $error("uart tick missing");

  c_ext_exit: cover property (s_release ##7 state_q == ST_RUN);
  c_wdt_done: cover property (state_q == ST_WDT ##1 state_q == ST_EXIT);
  c_wdt_override: cover property (state_q == ST_WDT && ext_hold);
  c_xcvr_on: cover property (XCVR_PINS_OE);

endmodule : reset_entry_exit_sequencer

// ---- verif/board_model.sv ----
// Board side: reset circuit and external UART clock source
`timescale 1ns/100ps
module board_model
  import rst_seq_pkg::*;
#(
  parameter int HOLD = MIN_EXT_RESET_CYC
) (
  input wire logic clk,
  input wire logic rst_req,
  input wire logic ext_clk_en,
  output logic rst_n,
  output logic ext_clk
);
  int cnt = 0;
  initial rst_n = 1'b1;
  initial ext_clk = 1'b0;
  // Asserted off the clock edge, as a real board would
  always @(posedge rst_req) #13 rst_n = 1'b0;
  // Clock keeps running all through the hold time
  always @(posedge clk) begin
    cnt <= rst_n ? 0 : cnt + 1;
    if (!rst_n && !rst_req && cnt >= HOLD) rst_n <= 1'b1;
    ext_clk <= ext_clk_en && !ext_clk;
  end
endmodule : board_model

// ---- verif/reset_entry_exit_sequencer_test.sv ----
// Self-checking bench for the reset entry and exit sequencer
`timescale 1ns/100ps
module reset_entry_exit_sequencer_test;
  import rst_seq_pkg::*;
  localparam int WC = 16;
  localparam int K = SYNC_STAGES + 1;
  logic MCLK = 1'b0;
  logic ARST_N = 1'b0;
  logic WDT_TIMEOUT = 1'b0;
  logic FLAG_CLEAR = 1'b0;
  logic EXT_TRANSCEIVER_STRAP = 1'b1;
  logic XCVR_RECEIVE_DATA = 1'b0;
  logic rst_req = 1'b0;
  logic ext_clk_en = 1'b0;
  uart_clk_sel_t UART_CLK_SEL = '0;
  xcvr_out_t USB_TX = '0;
  logic EXT_RESET_IN_N, UART_EXT_CLOCK_IN, SYSTEM_RESET_DRIVE, CPU_RESET;
  logic BUS_START, FETCH_START, WATCHDOG_RESET_CAUSE_FLAG, USB_RX;
  logic XCVR_PINS_OE;
  logic [19:0] FETCH_ADDR;
  uart_clk_sel_t UART_CLK_TICK;
  xcvr_out_t XCVR_PINS_O;
  int n_errors = 0;
  int checks_done = 0;
  int seed = 68952;
  int c0, c1;

  always #(CLK_PERIOD_NS / 2) MCLK = ~MCLK;

  reset_entry_exit_sequencer #(.WDT_EXIT_CYC(WC))
    reset_entry_exit_sequencer_i (.MCLK, .ARST_N, .EXT_RESET_IN_N,
    .WDT_TIMEOUT, .FLAG_CLEAR, .SYSTEM_RESET_DRIVE, .CPU_RESET, .BUS_START,
    .FETCH_START, .FETCH_ADDR, .WATCHDOG_RESET_CAUSE_FLAG, .UART_CLK_SEL,
    .UART_EXT_CLOCK_IN, .UART_CLK_TICK, .EXT_TRANSCEIVER_STRAP, .USB_TX,
    .USB_RX, .XCVR_PINS_O, .XCVR_PINS_OE, .XCVR_RECEIVE_DATA);

  board_model board_model_i (.clk(MCLK), .rst_req, .ext_clk_en,
    .rst_n(EXT_RESET_IN_N), .ext_clk(UART_EXT_CLOCK_IN));

  function automatic xcvr_out_t exp_pins(logic s, xcvr_out_t t);
    return s ? '0 : t;
  endfunction : exp_pins

  task automatic chk(logic [19:0] g, logic [19:0] x);
    checks_done++;
    if (g !== x) begin
      n_errors++;
      $display("MISMATCH %0t got %h exp %h", $time, g, x);
    end
  endtask : chk

  task automatic wrap_up;
    if (n_errors == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : wrap_up

  // Edge k is the first edge that sees the synchronised release; each
  // output is looked at just after edge e, so a pulse counted as cycle n
  // from edge k is already standing after edge k+n-1
  task automatic walk(int k, logic fl);
    for (int e = 1; e <= k + 8; e++) begin
      @(posedge MCLK);
      #1;
      chk(BUS_START, e == k + BUS_START_CYC - 1);
      chk(FETCH_START, e == k + FETCH_START_CYC - 1);
      chk(FETCH_ADDR,
        e == k + FETCH_START_CYC - 1 ? RESET_VECTOR : '0);
      chk(CPU_RESET, e < k + FETCH_START_CYC - 1);
      chk(SYSTEM_RESET_DRIVE, e < k + RST_OUT_HOLD_CYC);
    end
    chk(WATCHDOG_RESET_CAUSE_FLAG, fl);
  endtask : walk

  task automatic hold_pin(logic s);
    @(negedge MCLK);
    EXT_TRANSCEIVER_STRAP = s;
    rst_req = 1'b1;
    @(negedge EXT_RESET_IN_N);
    #5;
    chk(SYSTEM_RESET_DRIVE, 1'b1);
    chk(CPU_RESET, 1'b1);
    @(negedge MCLK);
    rst_req = 1'b0;
    @(posedge EXT_RESET_IN_N);
  endtask : hold_pin

  task automatic wdt_pulse;
    @(negedge MCLK);
    WDT_TIMEOUT = 1'b1;
    @(negedge MCLK);
    WDT_TIMEOUT = 1'b0;
  endtask : wdt_pulse

  // Strap moves randomly here too: only the value at release counts
  task automatic pins(logic s);
    repeat (4) begin
      @(negedge MCLK);
      USB_TX = 3'($random(seed));
      XCVR_RECEIVE_DATA = 1'($random(seed));
      EXT_TRANSCEIVER_STRAP = 1'($random(seed));
      @(posedge MCLK);
      #1;
      chk(XCVR_PINS_O, exp_pins(s, USB_TX));
      chk(XCVR_PINS_OE, !s);
      chk(USB_RX, !s & XCVR_RECEIVE_DATA);
    end
  endtask : pins

  initial begin
    repeat (5) @(negedge MCLK);
    ARST_N = 1'b1;
    walk(K, 1'b0);
    pins(1'b1);
    for (int s = 0; s < 4; s++) begin
      @(negedge MCLK);
      UART_CLK_SEL = 2'(s);
      c0 = 0;
      c1 = 0;
      repeat (2) @(negedge MCLK);
      for (int c = 0; c < 24; c++) begin
        @(negedge MCLK);
        ext_clk_en = c < 20;
        @(posedge MCLK);
        #1;
        c0 += UART_CLK_TICK.std_uart;
        c1 += UART_CLK_TICK.hs_uart;
      end
      chk(c0, s[0] ? 10 : 24);
      chk(c1, s[1] ? 10 : 24);
    end
    // Timeout taken at edge j; the last count is seen WC edges later
    wdt_pulse;
    walk(WC, 1'b1);
    @(negedge MCLK);
    FLAG_CLEAR = 1'b1;
    @(negedge MCLK);
    FLAG_CLEAR = 1'b0;
    chk(WATCHDOG_RESET_CAUSE_FLAG, 1'b0);
    wdt_pulse;
    walk(WC, 1'b1);
    wdt_pulse;
    repeat (5) @(posedge MCLK);
    hold_pin(1'b1);
    walk(K, 1'b0);
    hold_pin(1'b0);
    // Re-assert while the first bus cycle stands, before the fetch
    repeat (7) @(posedge MCLK);
    hold_pin(1'b0);
    walk(K, 1'b0);
    pins(1'b0);
    wrap_up;
  end

  initial begin
    #(80000 * CLK_PERIOD_NS);
    n_errors++;
    wrap_up;
  end
endmodule : reset_entry_exit_sequencer_test
